// ---- pkg/phdtc_pkg.sv ----
`default_nettype none

package phdtc_pkg;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int unsigned NUM_WIRES  = 9;
  localparam int unsigned TEMP_W     = 8;
  localparam int unsigned ADDR_W     = 12;

  // ---------------------------------------------------------------
  // Temperature thresholds, degrees Celsius
  // ---------------------------------------------------------------
  localparam logic [TEMP_W-1:0] HEAD_INTERVAL_C = 8'h6E;
  localparam logic [TEMP_W-1:0] HEAD_STOP_C     = 8'h78;
  localparam logic [TEMP_W-1:0] HEAD_RESUME_C   = 8'h64;
  localparam logic [TEMP_W-1:0] FAN_ON_C        = 8'h41;
  localparam logic [TEMP_W-1:0] FAN_OFF_C       = 8'h32;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_CTRL    = 12'h000;
  localparam logic [ADDR_W-1:0] REG_WIRES   = 12'h004;
  localparam logic [ADDR_W-1:0] REG_TEMP    = 12'h008;
  localparam logic [ADDR_W-1:0] REG_STATUS  = 12'h00C;
  localparam logic [ADDR_W-1:0] REG_IRQ_ST  = 12'h010;
  localparam logic [ADDR_W-1:0] REG_IRQ_MSK = 12'h014;

  // Control register fields
  localparam int unsigned CTRL_MASTER_BIT = 0;
  localparam int unsigned CTRL_FCLR_BIT   = 1;

  // Wire register fields
  localparam int unsigned WIRE_RIGHT_LSB = 0;
  localparam int unsigned WIRE_LEFT_LSB  = 16;

  // Temperature register fields
  localparam int unsigned TEMP_HEAD_LSB = 0;
  localparam int unsigned TEMP_FAN_LSB  = 8;

  // Interrupt / status event bits
  localparam int unsigned NUM_EVT       = 4;
  localparam int unsigned EVT_FAULT     = 0;
  localparam int unsigned EVT_INTERVAL  = 1;
  localparam int unsigned EVT_STOP      = 2;
  localparam int unsigned EVT_FAN       = 3;

  // Reset values
  localparam logic [NUM_EVT-1:0]   EVT_RESET  = 4'h0;
  localparam logic [NUM_WIRES-1:0] WIRE_RESET = 9'h000;
  localparam logic [TEMP_W-1:0]    TEMP_RESET = 8'h00;

  // Input synchroniser depth
  localparam int unsigned SYNC_STAGES = 3;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0]
  {
    PHDTC_NORMAL,
    PHDTC_INTERVAL,
    PHDTC_STOPPED
  } phdtc_head_st_t;

  typedef struct packed
  {
    logic [NUM_WIRES-1:0] right;
    logic [NUM_WIRES-1:0] left;
  } phdtc_wires_t;

  typedef struct packed
  {
    logic [TEMP_W-1:0] head;
    logic [TEMP_W-1:0] fan;
  } phdtc_temps_t;

endpackage : phdtc_pkg

`default_nettype wire

// ---- src/phdtc_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

// Three-stage synchroniser; a change counts once stages two and three agree
module phdtc_sync
  import phdtc_pkg::*;
#(
  parameter int unsigned WIDTH = 1
)
(
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  input  wire logic [WIDTH-1:0] d_i,
  output var  logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] q_q;
  logic [WIDTH-1:0] q_d;

  assign q_d = (s2_q == s3_q) ? s3_q : q_q;
  assign q_o = q_q;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q_q  <= '0;
    end
    else
    begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q_q  <= q_d;
    end
  end

endmodule : phdtc_sync

`default_nettype wire

// ---- src/phdtc_top.sv ----
// Function
// RULE_01: Each of the nine wire drive outputs per side is active high and turns on its coil.
// RULE_02: Each high-side drive output follows its wire drive output in the same cycle.
// RULE_03: With the master head drive low, every coil drive output is forced low.
// RULE_04: A high on either channel driver fault input raises the driver fault output.
// RULE_05: The power board removes its output voltage and the printer beeps on a fault.
// RULE_06: Below 110 C with no thermal stop in force, normal printing is allowed.
// RULE_07: At 110 C or more the block asks for interval printing with longer rests.
// RULE_08: At 120 C or more printing halts and stays halted until 100 C or below.
// RULE_09: After a thermal stop, falling to 100 C or below returns to normal printing.
// RULE_10: Below 65 C with the fan not started, the head fan stays off.
// RULE_11: At 65 C or more the head fan is switched on.
// RULE_12: A running head fan stops only at 50 C or below.
// RULE_13: Temperatures arrive as digital readings; print and fan states are registered.
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module phdtc_top
  import phdtc_pkg::*;
(
  input  wire logic                 CLK_I,
  input  wire logic                 ARST_N_I,
  input  wire logic [ADDR_W-1:0]    PADDR_I,
  input  wire logic                 PSEL_I,
  input  wire logic                 PENABLE_I,
  input  wire logic                 PWRITE_I,
  input  wire logic [31:0]          PWDATA_I,
  output var  logic [31:0]          PRDATA_O,
  output var  logic                 PREADY_O,
  output var  logic                 PSLVERR_O,
  input  wire logic                 PCHAN_DRIVER_FAULT_IN_I,
  input  wire logic                 NCHAN_DRIVER_FAULT_IN_I,
  output var  logic [NUM_WIRES-1:0] RIGHT_WIRE_DRIVE_O,
  output var  logic [NUM_WIRES-1:0] LEFT_WIRE_DRIVE_O,
  output var  logic [NUM_WIRES-1:0] RIGHT_HIGH_SIDE_DRIVE_O,
  output var  logic [NUM_WIRES-1:0] LEFT_HIGH_SIDE_DRIVE_O,
  output var  logic                 HEAD_MASTER_DRIVE_O,
  output var  logic                 DRIVER_FAULT_OUT_O,
  output var  logic                 PRINT_ALLOW_O,
  output var  logic                 PRINT_INTERVAL_O,
  output var  logic                 HEAD_FAN_O,
  output var  logic                 IRQ_O
);

  // ---------------------------------------------------------------
  // Fault input synchronisers
  // ---------------------------------------------------------------
  logic [1:0] fault_raw;
  logic [1:0] fault_sync;

  assign fault_raw = {PCHAN_DRIVER_FAULT_IN_I, NCHAN_DRIVER_FAULT_IN_I};

  phdtc_sync #(
    .WIDTH (2)
  ) u_fault_sync (
    .clk_i    (CLK_I),
    .arst_n_i (ARST_N_I),
    .d_i      (fault_raw),
    .q_o      (fault_sync)
  );

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  logic         acc_w;
  logic         wr_w;
  logic         hit_ctrl;
  logic         hit_wires;
  logic         hit_temp;
  logic         hit_status;
  logic         hit_irq_st;
  logic         hit_irq_msk;
  logic         hit_any;

  assign acc_w       = PSEL_I & PENABLE_I;
  assign wr_w        = acc_w & PWRITE_I;
  assign hit_ctrl    = (PADDR_I == REG_CTRL);
  assign hit_wires   = (PADDR_I == REG_WIRES);
  assign hit_temp    = (PADDR_I == REG_TEMP);
  assign hit_status  = (PADDR_I == REG_STATUS);
  assign hit_irq_st  = (PADDR_I == REG_IRQ_ST);
  assign hit_irq_msk = (PADDR_I == REG_IRQ_MSK);
  assign hit_any     = hit_ctrl | hit_wires | hit_temp | hit_status
                     | hit_irq_st | hit_irq_msk;

  // ---------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------
  logic                 master_q;
  logic                 master_d;
  phdtc_wires_t         wires_q;
  phdtc_wires_t         wires_d;
  phdtc_temps_t         temps_q;
  phdtc_temps_t         temps_d;
  logic [NUM_EVT-1:0]   irq_msk_q;
  logic [NUM_EVT-1:0]   irq_msk_d;
  logic                 fault_clr_w;

  assign master_d  = (wr_w & hit_ctrl) ? PWDATA_I[CTRL_MASTER_BIT] : master_q;
  assign fault_clr_w = wr_w & hit_ctrl & PWDATA_I[CTRL_FCLR_BIT];
  assign wires_d.right = (wr_w & hit_wires)
                       ? PWDATA_I[WIRE_RIGHT_LSB +: NUM_WIRES] : wires_q.right;
  assign wires_d.left  = (wr_w & hit_wires)
                       ? PWDATA_I[WIRE_LEFT_LSB +: NUM_WIRES] : wires_q.left;
  // RULE_13
  assign temps_d.head  = (wr_w & hit_temp)
                       ? PWDATA_I[TEMP_HEAD_LSB +: TEMP_W] : temps_q.head;
  assign temps_d.fan   = (wr_w & hit_temp)
                       ? PWDATA_I[TEMP_FAN_LSB +: TEMP_W] : temps_q.fan;
  assign irq_msk_d = (wr_w & hit_irq_msk) ? PWDATA_I[NUM_EVT-1:0] : irq_msk_q;

  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      master_q  <= 1'b0;
      wires_q   <= {WIRE_RESET, WIRE_RESET};
      temps_q   <= {TEMP_RESET, TEMP_RESET};
      irq_msk_q <= EVT_RESET;
    end
    else
    begin
      master_q  <= master_d;
      wires_q   <= wires_d;
      temps_q   <= temps_d;
      irq_msk_q <= irq_msk_d;
    end
  end

  // ---------------------------------------------------------------
  // Driver fault latch
  // ---------------------------------------------------------------
  logic fault_now;
  logic fault_q;
  logic fault_d;

  assign fault_now = |fault_sync; // RULE_04
  // Set wins over software clear
  assign fault_d   = fault_now | (fault_q & ~fault_clr_w); // RULE_04

  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      fault_q <= 1'b0;
    else
      fault_q <= fault_d;
  end

  // ---------------------------------------------------------------
  // Printhead thermal state
  // ---------------------------------------------------------------
  phdtc_head_st_t head_st_q;
  phdtc_head_st_t head_st_d;

  always_comb
  begin
    head_st_d = head_st_q;
    case (head_st_q)
      PHDTC_NORMAL:
      begin
        if (temps_q.head >= HEAD_STOP_C)
          head_st_d = PHDTC_STOPPED; // RULE_08
        else if (temps_q.head >= HEAD_INTERVAL_C)
          head_st_d = PHDTC_INTERVAL; // RULE_07
      end
      PHDTC_INTERVAL:
      begin
        if (temps_q.head >= HEAD_STOP_C)
          head_st_d = PHDTC_STOPPED; // RULE_08
        else if (temps_q.head < HEAD_INTERVAL_C)
          head_st_d = PHDTC_NORMAL; // RULE_06
      end
      PHDTC_STOPPED:
      begin
        if (temps_q.head <= HEAD_RESUME_C)
          head_st_d = PHDTC_NORMAL; // RULE_09
      end
      default:
        head_st_d = PHDTC_STOPPED;
    endcase
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      head_st_q <= PHDTC_NORMAL;
    else
      head_st_q <= head_st_d; // RULE_13
  end

  // ---------------------------------------------------------------
  // Head fan hysteresis
  // ---------------------------------------------------------------
  logic fan_q;
  logic fan_d;

  assign fan_d = fan_q ? (temps_q.fan > FAN_OFF_C)    // RULE_12
                       : (temps_q.fan >= FAN_ON_C);   // RULE_10 RULE_11

  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      fan_q <= 1'b0;
    else
      fan_q <= fan_d; // RULE_13
  end

  // ---------------------------------------------------------------
  // Coil drive outputs
  // ---------------------------------------------------------------
  logic                 drive_en_w;
  logic                 allow_w;
  logic [NUM_WIRES-1:0] right_d;
  logic [NUM_WIRES-1:0] left_d;

  assign allow_w    = (head_st_d != PHDTC_STOPPED); // RULE_06
  // Fault also drops drive so a shorted driver draws no current
  assign drive_en_w = master_d & allow_w & ~fault_d; // RULE_03

  genvar gi;
  generate
    for (gi = 0; gi < NUM_WIRES; gi++)
    begin : g_wire
      assign right_d[gi] = drive_en_w & wires_d.right[gi]; // RULE_01
      assign left_d[gi]  = drive_en_w & wires_d.left[gi];  // RULE_01
    end
  endgenerate

  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      RIGHT_WIRE_DRIVE_O      <= WIRE_RESET;
      LEFT_WIRE_DRIVE_O       <= WIRE_RESET;
      RIGHT_HIGH_SIDE_DRIVE_O <= WIRE_RESET;
      LEFT_HIGH_SIDE_DRIVE_O  <= WIRE_RESET;
      HEAD_MASTER_DRIVE_O     <= 1'b0;
    end
    else
    begin
      RIGHT_WIRE_DRIVE_O      <= right_d;
      LEFT_WIRE_DRIVE_O       <= left_d;
      RIGHT_HIGH_SIDE_DRIVE_O <= right_d; // RULE_02
      LEFT_HIGH_SIDE_DRIVE_O  <= left_d;  // RULE_02
      HEAD_MASTER_DRIVE_O     <= drive_en_w; // RULE_03
    end
  end

  // ---------------------------------------------------------------
  // Status outputs
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      DRIVER_FAULT_OUT_O <= 1'b0;
      PRINT_ALLOW_O      <= 1'b0;
      PRINT_INTERVAL_O   <= 1'b0;
      HEAD_FAN_O         <= 1'b0;
    end
    else
    begin
      DRIVER_FAULT_OUT_O <= fault_d; // RULE_04
      PRINT_ALLOW_O      <= allow_w & ~fault_d;
      PRINT_INTERVAL_O   <= (head_st_d == PHDTC_INTERVAL); // RULE_07
      HEAD_FAN_O         <= fan_d;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt events
  // ---------------------------------------------------------------
  logic [NUM_EVT-1:0] evt_w;
  logic [NUM_EVT-1:0] irq_st_q;
  logic [NUM_EVT-1:0] irq_st_d;
  logic [NUM_EVT-1:0] irq_clr_w;

  assign evt_w[EVT_FAULT]    = fault_d & ~fault_q;
  assign evt_w[EVT_INTERVAL] = (head_st_d == PHDTC_INTERVAL)
                             & (head_st_q != PHDTC_INTERVAL);
  assign evt_w[EVT_STOP]     = (head_st_d == PHDTC_STOPPED)
                             & (head_st_q != PHDTC_STOPPED);
  assign evt_w[EVT_FAN]      = fan_d ^ fan_q;
  assign irq_clr_w = (wr_w & hit_irq_st) ? PWDATA_I[NUM_EVT-1:0] : EVT_RESET;
  assign irq_st_d  = evt_w | (irq_st_q & ~irq_clr_w);

  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      irq_st_q <= EVT_RESET;
      IRQ_O    <= 1'b0;
    end
    else
    begin
      irq_st_q <= irq_st_d;
      IRQ_O    <= |(irq_st_d & irq_msk_d);
    end
  end

  // ---------------------------------------------------------------
  // APB read path
  // ---------------------------------------------------------------
  logic [31:0] rdata_w;
  logic [31:0] status_w;

  assign status_w = {24'h000000, 1'b0, fan_q, head_st_q == PHDTC_STOPPED,
                     head_st_q == PHDTC_INTERVAL, fault_sync, fault_q, master_q};

  always_comb
  begin
    rdata_w = 32'h00000000;
    if (hit_ctrl)
      rdata_w[CTRL_MASTER_BIT] = master_q;
    if (hit_wires)
    begin
      rdata_w[WIRE_RIGHT_LSB +: NUM_WIRES] = wires_q.right;
      rdata_w[WIRE_LEFT_LSB +: NUM_WIRES]  = wires_q.left;
    end
    if (hit_temp)
    begin
      rdata_w[TEMP_HEAD_LSB +: TEMP_W] = temps_q.head;
      rdata_w[TEMP_FAN_LSB +: TEMP_W]  = temps_q.fan;
    end
    if (hit_status)
      rdata_w = status_w;
    if (hit_irq_st)
      rdata_w[NUM_EVT-1:0] = irq_st_q;
    if (hit_irq_msk)
      rdata_w[NUM_EVT-1:0] = irq_msk_q;
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      PRDATA_O  <= 32'h00000000;
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end
    else
    begin
      PRDATA_O  <= (PSEL_I & ~PENABLE_I & ~PWRITE_I) ? rdata_w : PRDATA_O;
      PREADY_O  <= PSEL_I & ~PENABLE_I;
      PSLVERR_O <= PSEL_I & ~PENABLE_I & ~hit_any;
    end
  end

endmodule : phdtc_top

`default_nettype wire

// ---- bench/phdtc_top_properties.sv ----
`timescale 1ns/1ps
`default_nettype none

module phdtc_top_checker
  import phdtc_pkg::*;
(
  input wire logic                 CLK_I,
  input wire logic                 ARST_N_I,
  input wire logic [ADDR_W-1:0]    PADDR_I,
  input wire logic                 PSEL_I,
  input wire logic                 PENABLE_I,
  input wire logic                 PWRITE_I,
  input wire logic [31:0]          PWDATA_I,
  input wire logic                 PREADY_O,
  input wire logic                 PCHAN_DRIVER_FAULT_IN_I,
  input wire logic                 NCHAN_DRIVER_FAULT_IN_I,
  input wire logic [NUM_WIRES-1:0] RIGHT_WIRE_DRIVE_O,
  input wire logic [NUM_WIRES-1:0] LEFT_WIRE_DRIVE_O,
  input wire logic [NUM_WIRES-1:0] RIGHT_HIGH_SIDE_DRIVE_O,
  input wire logic [NUM_WIRES-1:0] LEFT_HIGH_SIDE_DRIVE_O,
  input wire logic                 HEAD_MASTER_DRIVE_O,
  input wire logic                 DRIVER_FAULT_OUT_O,
  input wire logic                 PRINT_ALLOW_O,
  input wire logic                 PRINT_INTERVAL_O,
  input wire logic                 HEAD_FAN_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);

  // Completed write to the temperature register
  wire logic       wr_t = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O && PADDR_I == REG_TEMP;
  wire logic [7:0] hd   = PWDATA_I[7:0];
  wire logic [7:0] fn   = PWDATA_I[15:8];

  a_high_side: assert property ({LEFT_HIGH_SIDE_DRIVE_O, RIGHT_HIGH_SIDE_DRIVE_O} ==
    {LEFT_WIRE_DRIVE_O, RIGHT_WIRE_DRIVE_O}) else $error("high side differs from wire drive");
  a_master_cut: assert property (!HEAD_MASTER_DRIVE_O |->
    (RIGHT_WIRE_DRIVE_O | LEFT_WIRE_DRIVE_O) == '0) else $error("coil driven without master");
  a_fault_raise: assert property (
    (PCHAN_DRIVER_FAULT_IN_I || NCHAN_DRIVER_FAULT_IN_I)[*4] |-> ##[0:2] DRIVER_FAULT_OUT_O)
    else $error("fault output not raised");
  a_fault_cuts: assert property (DRIVER_FAULT_OUT_O[*2] |->
    !HEAD_MASTER_DRIVE_O && !PRINT_ALLOW_O) else $error("drive kept during fault");
  a_stop_enter: assert property (wr_t && hd >= HEAD_STOP_C |-> ##2 !PRINT_ALLOW_O)
    else $error("no stop at high head temperature");
  a_stop_hold: assert property (wr_t && !PRINT_ALLOW_O && !DRIVER_FAULT_OUT_O
    && hd > HEAD_RESUME_C |-> ##2 !PRINT_ALLOW_O) else $error("stop released too early");
  a_resume_normal: assert property (wr_t && hd <= HEAD_RESUME_C && !DRIVER_FAULT_OUT_O
    |-> ##2 PRINT_ALLOW_O) else $error("no resume after cooling");
  a_interval_enter: assert property (wr_t && PRINT_ALLOW_O && hd >= HEAD_INTERVAL_C
    && hd < HEAD_STOP_C |-> ##2 PRINT_INTERVAL_O) else $error("no interval printing");
  a_fan_on: assert property (wr_t && fn >= FAN_ON_C |-> ##2 HEAD_FAN_O)
    else $error("fan not started");
  a_fan_off: assert property (wr_t && fn <= FAN_OFF_C |-> ##2 !HEAD_FAN_O)
    else $error("fan not stopped");
  a_fan_hold: assert property (wr_t && fn > FAN_OFF_C && fn < FAN_ON_C |->
    ##2 HEAD_FAN_O == $past(HEAD_FAN_O, 2)) else $error("fan changed inside band");
endmodule : phdtc_top_checker

bind phdtc_top phdtc_top_checker i_phdtc_top_checker (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I),
  .PADDR_I(PADDR_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
  .PWDATA_I(PWDATA_I), .PREADY_O(PREADY_O), .PCHAN_DRIVER_FAULT_IN_I(PCHAN_DRIVER_FAULT_IN_I),
  .NCHAN_DRIVER_FAULT_IN_I(NCHAN_DRIVER_FAULT_IN_I), .RIGHT_WIRE_DRIVE_O(RIGHT_WIRE_DRIVE_O),
  .LEFT_WIRE_DRIVE_O(LEFT_WIRE_DRIVE_O), .RIGHT_HIGH_SIDE_DRIVE_O(RIGHT_HIGH_SIDE_DRIVE_O),
  .LEFT_HIGH_SIDE_DRIVE_O(LEFT_HIGH_SIDE_DRIVE_O), .HEAD_MASTER_DRIVE_O(HEAD_MASTER_DRIVE_O),
  .DRIVER_FAULT_OUT_O(DRIVER_FAULT_OUT_O), .PRINT_ALLOW_O(PRINT_ALLOW_O),
  .PRINT_INTERVAL_O(PRINT_INTERVAL_O), .HEAD_FAN_O(HEAD_FAN_O));

`default_nettype wire

// ---- bench/phdtc_head_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module phdtc_head_model
  import phdtc_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         arst_n_i,
  input  wire logic         short_p_i,
  input  wire logic         short_n_i,
  input  wire logic         fault_i,
  input  wire logic         master_i,
  input  wire phdtc_wires_t wire_i,
  input  wire phdtc_wires_t hs_i,
  output var  logic         pfault_o,
  output var  logic         nfault_o,
  output var  logic         supply_on_o,
  output var  phdtc_wires_t coil_o
);
  logic pfault_q;
  logic nfault_q;
  logic supply_q;

  // Coil conducts only with both sides of the bridge and master on
  assign coil_o = wire_i & hs_i & {2*NUM_WIRES{master_i}};
  assign pfault_o = pfault_q;
  assign nfault_o = nfault_q;
  assign supply_on_o = supply_q;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pfault_q <= 1'b0;
      nfault_q <= 1'b0;
      supply_q <= 1'b1;
    end
    else
    begin
      pfault_q <= short_p_i;
      nfault_q <= short_n_i;
      // Power board stays off once told of a shorted driver
      if (fault_i)
        supply_q <= 1'b0;
    end
  end
endmodule : phdtc_head_model

`default_nettype wire

// ---- bench/phdtc_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module phdtc_tb
  import phdtc_pkg::*;
;
  logic              clk = 1'b0, arst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic              sp = 1'b0, sn = 1'b0;
  logic [ADDR_W-1:0] pa = 12'h000;
  logic [31:0]       pwd = 32'h0, prd, rd;
  logic              rdy, slv, slvs, flt, allow, intv, fan, irq, mst, pf, nf, sup;
  phdtc_wires_t      wd, hs, coil;
  int                err_count = 0, total_checks = 0, cyc = 0;
  // Entry: 18:16 expected fan/allow/interval, 15:8 fan C, 7:0 head C
  logic [31:0]       tt [8] = '{32'h0002_406D, 32'h0007_416E, 32'h0007_3377, 32'h0000_3278,
                                32'h0000_3365, 32'h0002_4064, 32'h0007_FF73, 32'h0002_006D};

  phdtc_top i_phdtc_top (.CLK_I(clk), .ARST_N_I(arst_n), .PADDR_I(pa), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(rdy),
    .PSLVERR_O(slv), .PCHAN_DRIVER_FAULT_IN_I(pf), .NCHAN_DRIVER_FAULT_IN_I(nf),
    .RIGHT_WIRE_DRIVE_O(wd.right), .LEFT_WIRE_DRIVE_O(wd.left),
    .RIGHT_HIGH_SIDE_DRIVE_O(hs.right), .LEFT_HIGH_SIDE_DRIVE_O(hs.left),
    .HEAD_MASTER_DRIVE_O(mst), .DRIVER_FAULT_OUT_O(flt), .PRINT_ALLOW_O(allow),
    .PRINT_INTERVAL_O(intv), .HEAD_FAN_O(fan), .IRQ_O(irq));

  phdtc_head_model i_phdtc_head_model (.clk_i(clk), .arst_n_i(arst_n), .short_p_i(sp),
    .short_n_i(sn), .fault_i(flt), .master_i(mst), .wire_i(wd), .hs_i(hs), .pfault_o(pf),
    .nfault_o(nf), .supply_on_o(sup), .coil_o(coil));

  always #2 clk = ~clk;

  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic apb(input logic [ADDR_W-1:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    pa <= a;
    pwr <= w;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = prd;
    slvs = slv;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_count++;
      end_sim();
    end
  end

  initial
  begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 6; i++)
    begin
      apb(12'(i * 4), 1'b0, 32'h0);
      chk("reset value", rd, 32'h0);
    end
    chk("idle outputs", {allow, intv, fan}, 32'h4);
    apb(12'h018, 1'b1, 32'hFFFF_FFFF);
    apb(12'h018, 1'b0, 32'h0);
    chk("unmapped data", rd, 32'h0);
    chk("unmapped error", slvs, 32'h1);
    apb(REG_CTRL, 1'b1, 32'h1);
    foreach (tt[i])
    begin
      apb(REG_WIRES, 1'b1, tt[i] ^ 32'h01A5_015A);
      chk("coils", coil, {tt[i][8:0] ^ 9'h15A, tt[i][24:16] ^ 9'h1A5});
    end
    apb(REG_CTRL, 1'b1, 32'h0);
    chk("master off", {mst, wd}, 32'h0);
    chk("coils off", coil, 32'h0);
    foreach (tt[i])
    begin
      apb(REG_TEMP, 1'b1, {16'h0, tt[i][15:0]});
      @(posedge clk);
      chk("print", {allow, intv}, {30'h0, tt[i][17:16]});
      chk("fan", fan, {31'h0, tt[i][18]});
    end
    apb(REG_IRQ_ST, 1'b0, 32'h0);
    chk("events", rd, 32'hE);
    chk("irq masked", irq, 32'h0);
    apb(REG_IRQ_MSK, 1'b1, 32'h4);
    @(posedge clk);
    chk("irq raised", irq, 32'h1);
    apb(REG_IRQ_ST, 1'b1, 32'h4);
    @(posedge clk);
    chk("irq cleared", irq, 32'h0);
    apb(REG_CTRL, 1'b1, 32'h1);
    sp <= 1'b1;
    repeat (8) @(posedge clk);
    chk("p fault", {flt, allow, mst, sup, coil}, 32'h8 << 18);
    sp <= 1'b0;
    repeat (4) @(posedge clk);
    apb(REG_CTRL, 1'b1, 32'h3);
    @(posedge clk);
    chk("fault cleared", {flt, mst}, 32'h1);
    sn <= 1'b1;
    repeat (8) @(posedge clk);
    apb(REG_CTRL, 1'b1, 32'h3);
    chk("n fault held", flt, 32'h1);
    apb(REG_IRQ_ST, 1'b0, 32'h0);
    chk("fault event", rd, 32'hB);
    sn <= 1'b0;
    repeat (4) @(posedge clk);
    apb(REG_CTRL, 1'b1, 32'h3);
    @(posedge clk);
    chk("n cleared", {flt, allow}, 32'h1);
    end_sim();
  end
endmodule : phdtc_tb

`default_nettype wire
